// ===== core/lfs_top.sv
module lfs_top #(
  parameter int PON_CYCLES = lfs_pkg::PON_DELAY_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control pins and qualified analog events
  input wire logic shutdown_high_input,
  input wire logic shutdown_low_input,
  input wire logic laser_disable_input,
  input wire logic fault_delay_strap,
  input wire logic supply_low,
  input wire logic optical_fault,
  input wire logic duty_const_high,
  input wire logic duty_const_low,
  // laser control outputs
  output logic bias_enable,
  output logic mod_enable,
  output logic sink_off_indicator,
  output logic laser_fault_flag,
  output logic hardware_alarm_low,
  output logic duty_monitor_enable,
  // axi4-lite write address and data
  input wire logic [lfs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [lfs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : apply_strb

  function automatic logic is_mapped(input logic [lfs_pkg::ADDR_W-1:0] addr);
    return (addr == lfs_pkg::OFS_CTRL) || (addr == lfs_pkg::OFS_FCONF) ||
           (addr == lfs_pkg::OFS_PON) || (addr == lfs_pkg::OFS_STATUS);
  endfunction : is_mapped

  // a limit of zero behaves as one cycle
  function automatic logic count_done(input logic [lfs_pkg::CNT_W-1:0] cnt,
                                      input logic [lfs_pkg::CNT_W-1:0] lim);
    return ({1'b0, cnt} + 25'h000_0001) >= {1'b0, lim};
  endfunction : count_done

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  lfs_pkg::lfs_pins_s pins_raw;
  lfs_pkg::lfs_pins_s pins;

  assign pins_raw = '{
    shutdown_high: shutdown_high_input,
    shutdown_low: shutdown_low_input,
    laser_disable: laser_disable_input,
    fault_delay_strap: fault_delay_strap,
    supply_low: supply_low,
    optical_fault: optical_fault,
    duty_const_high: duty_const_high,
    duty_const_low: duty_const_low
  };

  lfs_sync #(
    .W($bits(lfs_pkg::lfs_pins_s))
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d(pins_raw),
    .q(pins)
  );

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [lfs_pkg::CNT_W-1:0] fconf_reg;
  logic [lfs_pkg::CNT_W-1:0] pon_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [lfs_pkg::ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic do_write;
  logic monitor_bypass;

  assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign monitor_bypass = ctrl_reg[lfs_pkg::CTRL_BYPASS_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= lfs_pkg::CTRL_RST;
      fconf_reg <= lfs_pkg::CNT_W'(lfs_pkg::FAULT_CONFIRM_CYC);
      pon_reg <= lfs_pkg::CNT_W'(PON_CYCLES);
    end else if (do_write) begin
      case (awaddr_reg)
        lfs_pkg::OFS_CTRL: ctrl_reg <= apply_strb(ctrl_reg, wdata_reg, wstrb_reg);
        lfs_pkg::OFS_FCONF: fconf_reg <= lfs_pkg::CNT_W'(apply_strb({8'h00, fconf_reg}, wdata_reg, wstrb_reg));
        lfs_pkg::OFS_PON: pon_reg <= lfs_pkg::CNT_W'(apply_strb({8'h00, pon_reg}, wdata_reg, wstrb_reg));
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_have_reg <= 1'b0;
      awaddr_reg <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_reg <= 1'b0;
      end
      s_axi_awready <= !(s_axi_awvalid && s_axi_awready) && !aw_have_reg && !s_axi_bvalid;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      w_have_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_reg <= 1'b0;
      end
      s_axi_wready <= !(s_axi_wvalid && s_axi_wready) && !w_have_reg && !s_axi_bvalid;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lfs_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(awaddr_reg) ? lfs_pkg::RESP_OKAY : lfs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // supervisor state machine
  // ---------------------------------------------------------------
  lfs_pkg::lfs_state_e state_reg;
  logic [lfs_pkg::CNT_W-1:0] delay_cnt_reg;
  logic extra_pending_reg;
  logic shutdown_act;
  logic reset_cond;
  logic delay_done;

  assign shutdown_act = pins.shutdown_high || !pins.shutdown_low;
  assign reset_cond = shutdown_act || pins.supply_low;
  assign delay_done = count_done(delay_cnt_reg, pon_reg);

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= lfs_pkg::ST_RESET;
      delay_cnt_reg <= '0;
    end else if (reset_cond) begin
      state_reg <= lfs_pkg::ST_RESET;
      delay_cnt_reg <= '0;
    end else begin
      case (state_reg)
        lfs_pkg::ST_RESET: begin
          state_reg <= lfs_pkg::ST_POWERON;
          delay_cnt_reg <= '0;
        end
        lfs_pkg::ST_POWERON: begin
          delay_cnt_reg <= delay_done ? '0 : delay_cnt_reg + 1'b1;
          if (delay_done) begin
            state_reg <= extra_pending_reg ? lfs_pkg::ST_EXTRA : lfs_pkg::ST_RUN;
          end
        end
        lfs_pkg::ST_EXTRA: begin
          delay_cnt_reg <= delay_done ? '0 : delay_cnt_reg + 1'b1;
          if (delay_done) begin
            state_reg <= lfs_pkg::ST_RUN;
          end
        end
        lfs_pkg::ST_RUN: state_reg <= lfs_pkg::ST_RUN;
        default: state_reg <= lfs_pkg::ST_RESET;
      endcase
    end
  end

  // a shutdown seen while the flag is up arms the second delay; set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      extra_pending_reg <= 1'b0;
    end else if (shutdown_act && laser_fault_flag) begin
      extra_pending_reg <= 1'b1;
    end else if (state_reg == lfs_pkg::ST_EXTRA && delay_done && !reset_cond) begin
      extra_pending_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // fault confirmation and latch
  // ---------------------------------------------------------------
  logic [lfs_pkg::CNT_W-1:0] fault_cnt_reg;
  logic fault_cond;
  logic fault_set;

  // fault_cond needs ST_RUN and no reset_cond, and a shutdown forces ST_RESET, so a restart
  // always sees the counter freshly cleared
  assign fault_cond = pins.optical_fault && state_reg == lfs_pkg::ST_RUN && !reset_cond &&
                      !pins.laser_disable && !pins.fault_delay_strap;
  assign fault_set = fault_cond && count_done(fault_cnt_reg, fconf_reg);

  always_ff @(posedge clk) begin
    if (rst) begin
      fault_cnt_reg <= '0;
    end else if (!fault_cond || laser_fault_flag) begin
      fault_cnt_reg <= '0;
    end else begin
      fault_cnt_reg <= fault_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      laser_fault_flag <= 1'b0;
    end else if (fault_set) begin
      laser_fault_flag <= 1'b1;
    end else if (reset_cond) begin
      laser_fault_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // enables, monitor and alarm
  // ---------------------------------------------------------------
  logic duty_bad;
  logic run_ok;

  // monitor bypass stands in for switching the monitor off externally
  assign duty_bad = (pins.duty_const_high || pins.duty_const_low) && !monitor_bypass;
  // reset_cond is folded in so outputs drop one cycle after the synced pin
  assign run_ok = state_reg == lfs_pkg::ST_RUN && !reset_cond && !laser_fault_flag && !fault_set &&
                  !pins.laser_disable && !duty_bad;

  always_ff @(posedge clk) begin
    if (rst) begin
      bias_enable <= 1'b0;
      mod_enable <= 1'b0;
      sink_off_indicator <= 1'b1;
      hardware_alarm_low <= 1'b0;
      duty_monitor_enable <= 1'b0;
    end else begin
      bias_enable <= run_ok;
      mod_enable <= run_ok;
      sink_off_indicator <= !run_ok;
      hardware_alarm_low <= state_reg == lfs_pkg::ST_RUN && !reset_cond && !duty_bad;
      duty_monitor_enable <= !duty_bad;
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  lfs_pkg::lfs_status_s status;

  assign status = '{
    pad: '0,
    strap: pins.fault_delay_strap,
    extra_pending: extra_pending_reg,
    state: state_reg,
    monitor_en: duty_monitor_enable,
    alarm_low: hardware_alarm_low,
    sink_off: sink_off_indicator,
    mod_en: mod_enable,
    bias_en: bias_enable,
    fault_flag: laser_fault_flag
  };

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= lfs_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !(s_axi_arvalid && s_axi_arready) && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= is_mapped(s_axi_araddr) ? lfs_pkg::RESP_OKAY : lfs_pkg::RESP_SLVERR;
        case (s_axi_araddr)
          lfs_pkg::OFS_CTRL: s_axi_rdata <= ctrl_reg;
          lfs_pkg::OFS_FCONF: s_axi_rdata <= {8'h00, fconf_reg};
          lfs_pkg::OFS_PON: s_axi_rdata <= {8'h00, pon_reg};
          lfs_pkg::OFS_STATUS: s_axi_rdata <= status;
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_fault_seen;
    laser_fault_flag && !reset_cond;
  endsequence

  sequence s_extra_entry;
    state_reg == lfs_pkg::ST_POWERON && delay_done && extra_pending_reg && !reset_cond;
  endsequence

  a_fault_held: assert property (s_fault_seen |=> laser_fault_flag)
    else $error("fault flag dropped without a clear condition");
  a_fault_clear_cause: assert property ($fell(laser_fault_flag) |-> $past(reset_cond))
    else $error("fault flag cleared without shutdown or undervoltage");
  a_disable_no_clear: assert property (pins.laser_disable and s_fault_seen |=> laser_fault_flag)
    else $error("laser disable cleared the fault flag");
  a_strap_suppress: assert property (pins.fault_delay_strap && !laser_fault_flag |=> !laser_fault_flag)
    else $error("fault raised while strapped off");
  a_shutdown_off: assert property (shutdown_act |=> state_reg == lfs_pkg::ST_RESET && !bias_enable &&
                                   !mod_enable && sink_off_indicator)
    else $error("shutdown did not force reset and enables off");
  a_extra_delay: assert property (s_extra_entry |=> state_reg == lfs_pkg::ST_EXTRA ##1
                                  state_reg != lfs_pkg::ST_RUN || reset_cond)
    else $error("extra delay skipped after fault");
  a_supply_alarm: assert property (pins.supply_low |=> !hardware_alarm_low && !bias_enable)
    else $error("undervoltage did not pull alarm low");
  a_poweron_hold: assert property (state_reg == lfs_pkg::ST_POWERON |=> !bias_enable && sink_off_indicator)
    else $error("enables active during power-on delay");
  a_confirm_count: assert property ($rose(laser_fault_flag) |->
                                    $past(fault_cond) && $past(count_done(fault_cnt_reg, fconf_reg)))
    else $error("fault flagged before confirm time elapsed");
  a_enable_pair: assert property (bias_enable == mod_enable && sink_off_indicator == !bias_enable)
    else $error("bias and modulation enables disagree");
  a_monitor_kill: assert property (duty_bad |=> !duty_monitor_enable && !hardware_alarm_low &&
                                   sink_off_indicator)
    else $error("bad duty cycle did not disable laser");
  a_fault_override: assert property (laser_fault_flag |=> !bias_enable)
    else $error("laser on with fault latched");

endmodule : lfs_top

// ===== core/lfs_pkg.sv
package lfs_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int FAULT_CONFIRM_NS = 40000;
  localparam int PON_DELAY_NS = 1000000;
  // least times round up to whole cycles
  localparam int FAULT_CONFIRM_CYC = (FAULT_CONFIRM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PON_DELAY_CYC = (PON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 24;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FCONF = 8'h04;
  localparam logic [7:0] OFS_PON = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam int CTRL_BYPASS_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET = 4'h1,
    ST_POWERON = 4'h2,
    ST_EXTRA = 4'h4,
    ST_RUN = 4'h8
  } lfs_state_e;

  typedef struct packed {
    logic shutdown_high;
    logic shutdown_low;
    logic laser_disable;
    logic fault_delay_strap;
    logic supply_low;
    logic optical_fault;
    logic duty_const_high;
    logic duty_const_low;
  } lfs_pins_s;

  typedef struct packed {
    logic [19:0] pad;
    logic strap;
    logic extra_pending;
    logic [3:0] state;
    logic monitor_en;
    logic alarm_low;
    logic sink_off;
    logic mod_en;
    logic bias_en;
    logic fault_flag;
  } lfs_status_s;

endpackage : lfs_pkg

// ===== core/lfs_sync.sv
module lfs_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ---------------------------------------------------------------
  // two-stage synchroniser, first stage feeds only the second
  // ---------------------------------------------------------------
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : lfs_sync

// ===== bench/lfs_host_model.sv
module lfs_host_model #(
  parameter int HOLD = 12
) (
  // clock
  input wire logic clk,
  // requested and driven pin levels
  input wire lfs_pkg::lfs_pins_s cmd,
  output lfs_pkg::lfs_pins_s pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // board logic driving the control pins
  // ---------------------------------------------------------------
  // idle: shutdowns released, supply good, no events
  lfs_pkg::lfs_pins_s pins_reg = 8'h40;
  int age_reg = 0;
  logic active;

  assign active = pins_reg.shutdown_high | ~pins_reg.shutdown_low | pins_reg.laser_disable;
  assign pins = pins_reg;

  // a short shutdown or disable request from the bench is stretched, never cut short
  always_ff @(posedge clk) begin
    age_reg <= active ? age_reg + 1 : 0;
    pins_reg <= cmd;
    if (active && age_reg < HOLD) begin
      pins_reg.shutdown_high <= cmd.shutdown_high | pins_reg.shutdown_high;
      pins_reg.shutdown_low <= cmd.shutdown_low & pins_reg.shutdown_low;
      pins_reg.laser_disable <= cmd.laser_disable | pins_reg.laser_disable;
    end
  end
endmodule : lfs_host_model

// ===== bench/test_laser_fault_supervisor.sv
module test_laser_fault_supervisor;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int PON = 20;
  localparam int FC = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  lfs_pkg::lfs_pins_s cmd = 8'h40;
  lfs_pkg::lfs_pins_s pins;
  logic bias_enable, mod_enable, sink_off_indicator, laser_fault_flag, hardware_alarm_low, duty_monitor_enable;
  logic [5:0] outs;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, data;
  int err_total = 0;
  int checks_done = 0;
  int n;

  assign outs = {bias_enable, mod_enable, sink_off_indicator, laser_fault_flag, hardware_alarm_low, duty_monitor_enable};

  initial begin
    forever #20 clk = ~clk;
  end

  lfs_host_model #(.HOLD(12)) i_host (.clk(clk), .cmd(cmd), .pins(pins));

  lfs_top #(.PON_CYCLES(PON)) i_dut (
    .clk, .rst,
    .shutdown_high_input(pins.shutdown_high), .shutdown_low_input(pins.shutdown_low),
    .laser_disable_input(pins.laser_disable), .fault_delay_strap(pins.fault_delay_strap),
    .supply_low(pins.supply_low), .optical_fault(pins.optical_fault),
    .duty_const_high(pins.duty_const_high), .duty_const_low(pins.duty_const_low),
    .bias_enable, .mod_enable, .sink_off_indicator, .laser_fault_flag, .hardware_alarm_low, .duty_monitor_enable,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : chk_rng

  // counts falling edges until an output reaches a level, bounded
  task automatic wait_bit(input int idx, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (outs[idx] !== v && cnt < lim) begin
      @(negedge clk);
      cnt++;
    end
    chk("wait_level", {31'h0, v}, {31'h0, outs[idx]});
  endtask : wait_bit

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  initial begin
    #200_000;
    err_total++;
    $display("MISMATCH watchdog expected end seen hang");
    conclude();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("reset_outs", 6'b001000, outs);
    wait_bit(5, 1'b1, 4 * PON, n);
    chk_rng("poweron", PON, 2 * PON - 1, n);
    chk("run_outs", 6'b110011, outs);
    rd(lfs_pkg::OFS_FCONF, data, resp);
    chk("fconf_rst", 32'(lfs_pkg::FAULT_CONFIRM_CYC), data);
    rd(lfs_pkg::OFS_PON, data, resp);
    chk("pon_rst", 32'(PON), data);
    rd(lfs_pkg::OFS_CTRL, data, resp);
    chk("ctrl_rst", lfs_pkg::CTRL_RST, data);
    wr(lfs_pkg::OFS_FCONF, 32'hff00_000a, resp);
    chk("fconf_wresp", lfs_pkg::RESP_OKAY, resp);
    rd(lfs_pkg::OFS_FCONF, data, resp);
    chk("fconf_rd", 32'h0000_000a, data);
    wr(8'h10, 32'h0000_0001, resp);
    chk("unmapped_wresp", lfs_pkg::RESP_SLVERR, resp);
    rd(8'h10, data, resp);
    chk("unmapped_rresp", lfs_pkg::RESP_SLVERR, resp);
    chk("unmapped_rdata", 32'h0000_0000, data);
    wr(lfs_pkg::OFS_STATUS, 32'hffff_ffff, resp);
    chk("status_wresp", lfs_pkg::RESP_OKAY, resp);
    // only byte lane 1 may land
    s_axi_wstrb <= 4'h2;
    wr(lfs_pkg::OFS_CTRL, 32'hffff_fffe, resp);
    s_axi_wstrb <= 4'hf;
    rd(lfs_pkg::OFS_CTRL, data, resp);
    chk("ctrl_strb", 32'h0000_ff00, data);
    wr(lfs_pkg::OFS_CTRL, lfs_pkg::CTRL_RST, resp);
    @(negedge clk);
    cmd.optical_fault = 1'b1;
    repeat (FC / 2) @(negedge clk);
    cmd.optical_fault = 1'b0;
    repeat (FC + 6) @(negedge clk);
    chk("glitch", 6'b110011, outs);
    cmd.laser_disable = 1'b1;
    cmd.optical_fault = 1'b1;
    repeat (2 * FC) @(negedge clk);
    chk("disabled", 4'b0010, outs[5:2]);
    cmd.laser_disable = 1'b0;
    wait_bit(2, 1'b1, FC + 8, n);
    chk_rng("confirm", FC, FC + 8, n);
    chk("fault", 4'b0011, outs[5:2]);
    cmd.optical_fault = 1'b0;
    cmd.laser_disable = 1'b1;
    repeat (2 * FC) @(negedge clk);
    chk("latched", 4'b0011, outs[5:2]);
    cmd.laser_disable = 1'b0;
    cmd.duty_const_high = 1'b1;
    repeat (8) @(negedge clk);
    cmd.duty_const_high = 1'b0;
    repeat (8) @(negedge clk);
    chk("fault_over_duty", 4'b0011, outs[5:2]);
    cmd.shutdown_low = 1'b0;
    repeat (2 * FC) @(negedge clk);
    chk("shut_low", 5'b00100, outs[5:1]);
    cmd.shutdown_low = 1'b1;
    wait_bit(5, 1'b1, 4 * PON, n);
    chk_rng("extra_delay", 2 * PON, 3 * PON + 8, n);
    cmd.shutdown_high = 1'b1;
    repeat (2 * FC) @(negedge clk);
    chk("shut_high", 5'b00100, outs[5:1]);
    cmd.shutdown_high = 1'b0;
    wait_bit(5, 1'b1, 4 * PON, n);
    chk_rng("no_extra", PON, 2 * PON - 1, n);
    for (int k = 0; k < 2; k++) begin
      cmd.duty_const_high = (k == 0);
      cmd.duty_const_low = (k == 1);
      repeat (8) @(negedge clk);
      chk("duty_bad", 6'b001000, outs);
      cmd.duty_const_high = 1'b0;
      cmd.duty_const_low = 1'b0;
      wait_bit(5, 1'b1, 4 * PON, n);
      chk("duty_ok", 6'b110011, outs);
    end
    // monitor bypass: a stuck data level must not drop the laser
    wr(lfs_pkg::OFS_CTRL, 32'h0000_0001, resp);
    @(negedge clk);
    cmd.duty_const_low = 1'b1;
    repeat (8) @(negedge clk);
    chk("bypass", 6'b110011, outs);
    cmd.duty_const_low = 1'b0;
    repeat (4) @(negedge clk);
    wr(lfs_pkg::OFS_CTRL, lfs_pkg::CTRL_RST, resp);
    @(negedge clk);
    cmd.fault_delay_strap = 1'b1;
    cmd.optical_fault = 1'b1;
    repeat (3 * FC) @(negedge clk);
    chk("strap", 6'b110011, outs);
    cmd.fault_delay_strap = 1'b0;
    repeat (4) @(negedge clk);
    wait_bit(2, 1'b1, FC + 8, n);
    cmd.optical_fault = 1'b0;
    rd(lfs_pkg::OFS_STATUS, data, resp);
    chk("status_low", 32'h0000_0009, data & 32'h0000_000f);
    @(negedge clk);
    cmd.supply_low = 1'b1;
    repeat (8) @(negedge clk);
    chk("supply_low", 5'b00100, outs[5:1]);
    cmd.supply_low = 1'b0;
    wait_bit(5, 1'b1, 4 * PON, n);
    chk_rng("supply_pon", PON, 2 * PON - 1, n);
    conclude();
  end
endmodule : test_laser_fault_supervisor
